/* File: hbd_bridge_ctrl.sv */
// Operation
// - Enabled bridge drives A high, B low for phase high; reversed for low
// - Reaching chop threshold stops drive until the next PWM period starts
// - Fast decay reverses the bridge, then turns it off near zero current
// - Slow decay turns both low-side transistors on to recirculate current
// - Decay input low selects slow decay, high selects fast decay
// - Open decay input selects mixed decay
// - Disable with fast decay reverses until zero current, then coasts
// - Disable with slow decay brakes on both low sides, held after zero
// - Sense input ignored for blanking interval after drive begins
// - Blanking interval is also the minimum on-time of each period
// - Clear input low resets logic, disables bridge, ignores other inputs
// - Sleep low disables bridge, pump, regulator, clocks, ignores inputs
// - About one millisecond after sleep release before motion is accepted
// - Transistor limit held past qualification time disables bridge, trips fault
// - Overcurrent shutdown stays latched until clear or supply cycling
// - Any high or low side limit trips, independent of chop sense
// - Overheat disables bridge, trips fault, resumes by itself when cool
// - Low motor supply disables everything and resets logic until restored
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "hbd_map.svh"

module hbd_bridge_ctrl #(
    parameter int WAKE_CYC = (`HBD_WAKE_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS
) (
    input  wire logic        sys_clk,             // System clock, 20 MHz
    input  wire logic        rstn,                // Async reset, active low
    input  wire logic        wb_cyc_i,            // Wishbone cycle
    input  wire logic        wb_stb_i,            // Wishbone strobe
    input  wire logic        wb_we_i,             // Wishbone write
    input  wire logic [7:0]  wb_adr_i,            // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,            // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,            // Wishbone write data
    output logic      [31:0] wb_dat_o,            // Wishbone read data
    output logic             wb_ack_o,            // Wishbone acknowledge
    input  wire logic        phase_in,            // Direction pin
    input  wire logic        bridge_drive_on,     // Bridge enable pin
    input  wire logic        decay_sel_in,        // Decay pin level
    input  wire logic        decay_open_in,       // Decay pin floating
    input  wire logic        winding_sense_in,    // Chop comparator
    input  wire logic        current_zero_in,     // Winding current near zero
    input  wire logic [3:0]  fet_limit_in,        // Per-transistor limits
    input  wire logic        overheat_in,         // Die too hot
    input  wire logic        supply_low_lockout,  // Motor supply too low
    input  wire logic        logic_clear_n,       // Logic clear, active low
    input  wire logic        low_power_request_n, // Sleep, active low
    output logic             bridge_out_a_hs,     // Output A high side
    output logic             bridge_out_a_ls,     // Output A low side
    output logic             bridge_out_b_hs,     // Output B high side
    output logic             bridge_out_b_ls,     // Output B low side
    output logic             protection_trip_n,   // Fault, active low
    output logic             charge_pump_en,      // Gate pump run
    output logic             aux_regulator_out,   // Aux regulator enable
    output logic             clocks_run,          // Internal clocks run
    output logic             drive_ready          // Fully operational
);

    // Cycle counts derived from times
    localparam int BLANK_CYC = (`HBD_BLANK_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS;
    localparam int PWM_CYC   = `HBD_PWM_NS / `HBD_CLK_NS;
    localparam int MIXED_CYC = (`HBD_MIXED_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS;
    localparam int OCP_CYC   = (`HBD_OCP_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS;

    localparam logic [8:0]  PWM_LAST  = 9'(PWM_CYC - 1);
    localparam logic [8:0]  BLANK_C   = 9'(BLANK_CYC);
    localparam logic [8:0]  MIXED_C   = 9'(MIXED_CYC);
    localparam logic [6:0]  OCP_LAST  = 7'(OCP_CYC - 1);
    localparam logic [19:0] WAKE_LOAD = 20'(WAKE_CYC);

    hbd_pkg::hbd_regs_t  q;
    hbd_pkg::hbd_regs_t  n;
    hbd_pkg::hbd_decay_t decay;
    logic [`HBD_PIN_W-1:0] p;

    // Gate pattern {a_hs, a_ls, b_hs, b_ls}
    function automatic logic [3:0] hbd_gates(input hbd_pkg::hbd_gate_kind_t k,
                                             input logic dir);
        case (k)
            hbd_pkg::GK_DRIVE:   hbd_gates = dir ? 4'h9 : 4'h6;
            hbd_pkg::GK_REVERSE: hbd_gates = dir ? 4'h6 : 4'h9;
            hbd_pkg::GK_BRAKE:   hbd_gates = 4'h5;
            default:             hbd_gates = 4'h0;
        endcase
    endfunction : hbd_gates

    // Saturating nine-bit increment
    function automatic logic [8:0] hbd_inc9(input logic [8:0] v);
        hbd_inc9 = (v == 9'h1FF) ? v : 9'(v + 9'h001);
    endfunction : hbd_inc9

    // Second sync stage feeds all logic
    assign p = q.pin_s2;

    // Decay selection from pin
    always_comb begin
        if (p[`HBD_P_DECAY_OPEN]) begin
            decay = hbd_pkg::DK_MIXED;
        end else if (p[`HBD_P_DECAY]) begin
            decay = hbd_pkg::DK_FAST;
        end else begin
            decay = hbd_pkg::DK_SLOW;
        end
    end

    // Next-state logic
    always_comb begin
        logic en;
        logic period_start;
        logic ocp_hit;
        en           = 1'b0;
        period_start = 1'b0;
        ocp_hit      = 1'b0;
        n            = q;
        n.pin_s1 = {fet_limit_in, low_power_request_n, logic_clear_n,
                    supply_low_lockout, overheat_in, current_zero_in,
                    winding_sense_in, decay_open_in, decay_sel_in,
                    bridge_drive_on, phase_in};
        n.pin_s2 = q.pin_s1;

        // Wishbone slave, one wait state
        n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        n.dat = 32'h0000_0000;
        if (n.ack && !wb_we_i) begin
            case (wb_adr_i)
                `HBD_ADR_CTRL:   n.dat[`HBD_CTRL_FORCE_OFF] = q.force_off;
                `HBD_ADR_STATUS: begin
                    n.dat[`HBD_STS_STATE]    = q.st;
                    n.dat[`HBD_STS_OCP]      = q.ocp_latch;
                    n.dat[`HBD_STS_OVERHEAT] = p[`HBD_P_HOT];
                    n.dat[`HBD_STS_LOCKOUT]  = p[`HBD_P_LOW_SUPPLY];
                    n.dat[`HBD_STS_READY]    = q.ready;
                    n.dat[`HBD_STS_DECAY]    = decay;
                    n.dat[`HBD_STS_TRIP_N]   = q.trip_n;
                end
                `HBD_ADR_CHOPS:  n.dat[15:0] = q.chop_cnt;
                default:         n.dat = 32'h0000_0000;
            endcase
        end
        if (n.ack && wb_we_i && wb_adr_i == `HBD_ADR_CTRL && wb_sel_i[0]) begin
            n.force_off = wb_dat_i[`HBD_CTRL_FORCE_OFF];
        end

        // Fixed-frequency period and on-time counters
        period_start = (q.pwm_cnt == PWM_LAST);
        n.pwm_cnt    = period_start ? 9'h000 : 9'(q.pwm_cnt + 9'h001);
        n.on_cnt     = hbd_inc9(q.on_cnt);

        // Overcurrent qualification on any transistor
        if (|p[`HBD_P_LIMIT]) begin
            n.ocp_cnt = (q.ocp_cnt == 7'h7F) ? q.ocp_cnt : 7'(q.ocp_cnt + 7'h01);
        end else begin
            n.ocp_cnt = 7'h00;
        end
        ocp_hit = |p[`HBD_P_LIMIT] && (q.ocp_cnt >= OCP_LAST);
        en      = p[`HBD_P_ENABLE] & ~q.force_off;

        if (!p[`HBD_P_CLEAR_N] || p[`HBD_P_LOW_SUPPLY]) begin
            // Logic reset; lockout also drops pump and regulator
            n.st        = q.ready ? hbd_pkg::ST_IDLE : hbd_pkg::ST_WAKE;
            n.wake_cnt  = WAKE_LOAD;
            n.gate      = 4'h0;
            n.ocp_latch = 1'b0;
            n.ocp_cnt   = 7'h00;
            n.trip_n    = 1'b1;
            n.pwm_cnt   = 9'h000;
            n.chop_cnt  = 16'h0000;
            if (p[`HBD_P_LOW_SUPPLY]) begin
                n.cp_en   = 1'b0;
                n.aux_en  = 1'b0;
                n.clk_run = 1'b0;
                n.ready   = 1'b0;
                n.st      = hbd_pkg::ST_WAKE;
            end
        end else if (!p[`HBD_P_SLEEP_N]) begin
            // Sleep: everything stopped, inputs ignored
            n.st       = hbd_pkg::ST_SLEEP;
            n.gate     = 4'h0;
            n.cp_en    = 1'b0;
            n.aux_en   = 1'b0;
            n.clk_run  = 1'b0;
            n.ready    = 1'b0;
            n.pwm_cnt  = 9'h000;
            n.ocp_cnt  = 7'h00;
            n.wake_cnt = WAKE_LOAD;
        end else if (q.st == hbd_pkg::ST_SLEEP || q.st == hbd_pkg::ST_WAKE) begin
            // Wake-up delay before motion
            n.st      = hbd_pkg::ST_WAKE;
            n.gate    = 4'h0;
            n.cp_en   = 1'b1;
            n.aux_en  = 1'b1;
            n.clk_run = 1'b1;
            n.pwm_cnt = 9'h000;
            n.ocp_cnt = 7'h00;
            if (q.wake_cnt == 20'h00000) begin
                n.st    = hbd_pkg::ST_IDLE;
                n.ready = 1'b1;
            end else begin
                n.wake_cnt = q.wake_cnt - 20'h00001;
            end
        end else if (q.ocp_latch || ocp_hit || p[`HBD_P_HOT]) begin
            // Protection shutdown
            n.st        = hbd_pkg::ST_FAULT;
            n.gate      = 4'h0;
            n.trip_n    = 1'b0;
            n.ocp_latch = q.ocp_latch | ocp_hit;
        end else begin
            unique case (q.st)
                hbd_pkg::ST_FAULT: begin
                    // Overheat gone: resume
                    n.st     = hbd_pkg::ST_IDLE;
                    n.trip_n = 1'b1;
                    n.gate   = 4'h0;
                end
                hbd_pkg::ST_IDLE, hbd_pkg::ST_DIS_FAST: begin
                    if (en) begin
                        n.st     = hbd_pkg::ST_DRIVE;
                        n.dir    = p[`HBD_P_PHASE];
                        n.on_cnt = 9'h000;
                        n.gate   = hbd_gates(hbd_pkg::GK_DRIVE, p[`HBD_P_PHASE]);
                    end else if (q.st == hbd_pkg::ST_DIS_FAST) begin
                        if (p[`HBD_P_ZERO]) begin
                            n.st   = hbd_pkg::ST_IDLE;
                            n.gate = 4'h0;
                        end
                    end else if (decay == hbd_pkg::DK_SLOW) begin
                        n.gate = hbd_gates(hbd_pkg::GK_BRAKE, q.dir);
                    end else begin
                        n.gate = 4'h0;
                    end
                end
                hbd_pkg::ST_DRIVE, hbd_pkg::ST_CHOP_FAST,
                hbd_pkg::ST_CHOP_SLOW, hbd_pkg::ST_CHOP_OFF: begin
                    if (!en) begin
                        if (decay == hbd_pkg::DK_SLOW) begin
                            n.st   = hbd_pkg::ST_IDLE;
                            n.gate = hbd_gates(hbd_pkg::GK_BRAKE, q.dir);
                        end else begin
                            n.st   = hbd_pkg::ST_DIS_FAST;
                            n.gate = hbd_gates(hbd_pkg::GK_REVERSE, q.dir);
                        end
                    end else if (q.st == hbd_pkg::ST_DRIVE) begin
                        n.dir  = p[`HBD_P_PHASE];
                        n.gate = hbd_gates(hbd_pkg::GK_DRIVE, p[`HBD_P_PHASE]);
                        // Sense only counts after blanking
                        if (q.on_cnt >= BLANK_C && p[`HBD_P_SENSE]) begin
                            n.chop_cnt = 16'(q.chop_cnt + 16'h0001);
                            n.on_cnt   = 9'h000;
                            if (decay == hbd_pkg::DK_SLOW) begin
                                n.st   = hbd_pkg::ST_CHOP_SLOW;
                                n.gate = hbd_gates(hbd_pkg::GK_BRAKE, q.dir);
                            end else begin
                                n.st   = hbd_pkg::ST_CHOP_FAST;
                                n.gate = hbd_gates(hbd_pkg::GK_REVERSE, q.dir);
                            end
                        end
                    end else if (period_start) begin
                        n.st     = hbd_pkg::ST_DRIVE;
                        n.dir    = p[`HBD_P_PHASE];
                        n.on_cnt = 9'h000;
                        n.gate   = hbd_gates(hbd_pkg::GK_DRIVE, p[`HBD_P_PHASE]);
                    end else if (q.st == hbd_pkg::ST_CHOP_FAST) begin
                        if (p[`HBD_P_ZERO]) begin
                            n.st   = hbd_pkg::ST_CHOP_OFF;
                            n.gate = 4'h0;
                        end else if (decay == hbd_pkg::DK_MIXED && q.on_cnt >= MIXED_C) begin
                            n.st   = hbd_pkg::ST_CHOP_SLOW;
                            n.gate = hbd_gates(hbd_pkg::GK_BRAKE, q.dir);
                        end
                    end
                end
                default: begin
                    n.st   = hbd_pkg::ST_IDLE;
                    n.gate = 4'h0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q           <= '0;
            q.st        <= hbd_pkg::ST_SLEEP;
            q.trip_n    <= 1'b1;
            q.force_off <= `HBD_CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o            = q.dat;
    assign wb_ack_o            = q.ack;
    assign bridge_out_a_hs     = q.gate[3];
    assign bridge_out_a_ls     = q.gate[2];
    assign bridge_out_b_hs     = q.gate[1];
    assign bridge_out_b_ls     = q.gate[0];
    assign protection_trip_n   = q.trip_n;
    assign charge_pump_en      = q.cp_en;
    assign aux_regulator_out   = q.aux_en;
    assign clocks_run          = q.clk_run;
    assign drive_ready         = q.ready;

    // Drive pattern follows latched direction
    AST_DRIVE_DIR: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.st == hbd_pkg::ST_DRIVE |-> q.gate == (q.dir ? 4'h9 : 4'h6))
        else $error("drive pattern does not match direction");

    // No chop before blanking has elapsed
    AST_BLANK: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($past(q.st) == hbd_pkg::ST_DRIVE && (q.st == hbd_pkg::ST_CHOP_FAST ||
         q.st == hbd_pkg::ST_CHOP_SLOW)) |-> $past(q.on_cnt) >= BLANK_C)
        else $error("chop inside blanking interval");

    // Drive after fast-decay off (ST_CHOP_OFF) restarts only at period start
    AST_PERIOD: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($past(q.st) == hbd_pkg::ST_CHOP_OFF && q.st == hbd_pkg::ST_DRIVE)
        |-> $past(q.pwm_cnt) == PWM_LAST)
        else $error("drive resumed mid-period");

    // Fast decay reverses the bridge
    AST_FAST_REV: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.st == hbd_pkg::ST_CHOP_FAST |-> q.gate == (q.dir ? 4'h6 : 4'h9))
        else $error("fast decay not reversed");

    // Slow decay uses both low sides
    AST_SLOW_LS: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.st == hbd_pkg::ST_CHOP_SLOW |-> q.gate == 4'h5)
        else $error("slow decay not on low sides");

    // Disabled slow decay keeps braking
    AST_BRAKE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.st == hbd_pkg::ST_IDLE && $past(q.st) == hbd_pkg::ST_IDLE &&
         $past(decay) == hbd_pkg::DK_SLOW && $past(p[`HBD_P_CLEAR_N]) && q.ready) |-> q.gate == 4'h5)
        else $error("brake not held");

    // Latched overcurrent keeps bridge off and fault low
    AST_OCP_TRIP: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.ocp_latch |-> (!q.trip_n && q.gate == 4'h0))
        else $error("overcurrent shutdown incomplete");

    // Latch holds while clear and supply are good
    AST_OCP_LATCH: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.ocp_latch && p[`HBD_P_CLEAR_N] && !p[`HBD_P_LOW_SUPPLY]) |=> q.ocp_latch)
        else $error("overcurrent latch lost");

    // Clear input resets the bridge
    AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
        !p[`HBD_P_CLEAR_N] |=> (q.gate == 4'h0 && !q.ocp_latch && q.trip_n))
        else $error("clear did not reset");

    // Sleep stops pump, regulator, clocks and bridge
    AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!p[`HBD_P_SLEEP_N] && p[`HBD_P_CLEAR_N] && !p[`HBD_P_LOW_SUPPLY])
        |=> (!q.cp_en && !q.aux_en && !q.clk_run && q.gate == 4'h0))
        else $error("sleep incomplete");

    // Overheat trips within one cycle
    AST_HOT: assert property (@(posedge sys_clk) disable iff (!rstn)
        (p[`HBD_P_HOT] && p[`HBD_P_CLEAR_N] && p[`HBD_P_SLEEP_N] &&
         !p[`HBD_P_LOW_SUPPLY] && q.st != hbd_pkg::ST_SLEEP && q.st != hbd_pkg::ST_WAKE)
        |=> (!q.trip_n && q.gate == 4'h0))
        else $error("overheat not handled");

endmodule : hbd_bridge_ctrl
`default_nettype wire

/* File: hbd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hbd_map.svh"

module hbd_host_model (
    input  wire logic                 sys_clk,     // System clock
    input  wire logic                 drive_ready, // Device operational
    output var  logic [`HBD_PIN_W-1:0] pins        // Pin levels
);
    // Power-up: asleep, cleared, bridge off
    initial pins = '0;

    // One pin changed just after a rising edge
    task automatic put(input int i, input logic v);
        @(posedge sys_clk);
        pins[i] <= v;
    endtask : put

    // Clear and sleep released, then wake delay waited out
    task automatic wake(output logic ok);
        put(`HBD_P_CLEAR_N, 1'b1);
        put(`HBD_P_SLEEP_N, 1'b1);
        repeat (300) if (drive_ready !== 1'b1) @(negedge sys_clk);
        ok = drive_ready;
    endtask : wake
endmodule : hbd_host_model
`default_nettype wire

/* File: hbd_map.svh */
`ifndef HBD_MAP_SVH
`define HBD_MAP_SVH

// Clock and timing figures in ns
`define HBD_CLK_NS        50
`define HBD_BLANK_NS      3750
`define HBD_PWM_NS        20000
`define HBD_MIXED_NS      5000
`define HBD_OCP_NS        3000
`define HBD_WAKE_NS       1000000

// Register byte addresses
`define HBD_ADR_CTRL      8'h00
`define HBD_ADR_STATUS    8'h04
`define HBD_ADR_CHOPS     8'h08
`define HBD_CTRL_RST      1'h0

// Control register fields
`define HBD_CTRL_FORCE_OFF 0

// Status register fields
`define HBD_STS_STATE     3:0
`define HBD_STS_OCP       4
`define HBD_STS_OVERHEAT  5
`define HBD_STS_LOCKOUT   6
`define HBD_STS_READY     7
`define HBD_STS_DECAY     9:8
`define HBD_STS_TRIP_N    10

// Synchronised pin vector layout
`define HBD_PIN_W         14
`define HBD_P_PHASE       0
`define HBD_P_ENABLE      1
`define HBD_P_DECAY       2
`define HBD_P_DECAY_OPEN  3
`define HBD_P_SENSE       4
`define HBD_P_ZERO        5
`define HBD_P_HOT         6
`define HBD_P_LOW_SUPPLY  7
`define HBD_P_CLEAR_N     8
`define HBD_P_SLEEP_N     9
`define HBD_P_LIMIT       13:10

`endif

/* File: hbd_pkg.sv */
`default_nettype none
`include "hbd_map.svh"

package hbd_pkg;

    // Bridge controller states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_DRIVE     = 4'h1,
        ST_CHOP_FAST = 4'h2,
        ST_CHOP_SLOW = 4'h3,
        ST_CHOP_OFF  = 4'h4,
        ST_DIS_FAST  = 4'h5,
        ST_FAULT     = 4'h6,
        ST_SLEEP     = 4'h7,
        ST_WAKE      = 4'h8
    } hbd_state_t;

    // Decay selection
    typedef enum logic [1:0] {
        DK_SLOW  = 2'h0,
        DK_FAST  = 2'h1,
        DK_MIXED = 2'h2
    } hbd_decay_t;

    // Gate patterns
    typedef enum logic [1:0] {
        GK_OFF     = 2'h0,
        GK_DRIVE   = 2'h1,
        GK_REVERSE = 2'h2,
        GK_BRAKE   = 2'h3
    } hbd_gate_kind_t;

    // Complete block state
    typedef struct packed {
        logic [`HBD_PIN_W-1:0] pin_s1;
        logic [`HBD_PIN_W-1:0] pin_s2;
        hbd_state_t            st;
        logic                  dir;
        logic [3:0]            gate;
        logic [8:0]            pwm_cnt;
        logic [8:0]            on_cnt;
        logic [6:0]            ocp_cnt;
        logic [19:0]           wake_cnt;
        logic                  ocp_latch;
        logic                  trip_n;
        logic                  cp_en;
        logic                  aux_en;
        logic                  clk_run;
        logic                  ready;
        logic                  force_off;
        logic [15:0]           chop_cnt;
        logic                  ack;
        logic [31:0]           dat;
    } hbd_regs_t;

endpackage : hbd_pkg
`default_nettype wire

/* File: test_hbd_bridge_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hbd_map.svh"

module test_hbd_bridge_ctrl;
    logic                  sys_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  cyc = 1'b0;
    logic                  stb = 1'b0;
    logic                  we = 1'b0;
    logic [7:0]            adr = 8'h00;
    logic [31:0]           wdat = 32'h0;
    logic [31:0]           rdat;
    logic                  ack;
    logic                  ahs, als, bhs, bls, trip_n, pump, aux, clk_run, ready;
    logic [`HBD_PIN_W-1:0] p;
    logic [31:0]           q;
    logic                  ok;
    int                    miscompares = 0;
    int                    n_compared = 0;
    int                    cycles = 0;
    wire logic [3:0]       gt = {ahs, als, bhs, bls};

    hbd_bridge_ctrl #(.WAKE_CYC(20)) u_hbd_bridge_ctrl (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phase_in(p[`HBD_P_PHASE]), .bridge_drive_on(p[`HBD_P_ENABLE]),
        .decay_sel_in(p[`HBD_P_DECAY]), .decay_open_in(p[`HBD_P_DECAY_OPEN]),
        .winding_sense_in(p[`HBD_P_SENSE]), .current_zero_in(p[`HBD_P_ZERO]),
        .fet_limit_in(p[`HBD_P_LIMIT]), .overheat_in(p[`HBD_P_HOT]),
        .supply_low_lockout(p[`HBD_P_LOW_SUPPLY]), .logic_clear_n(p[`HBD_P_CLEAR_N]),
        .low_power_request_n(p[`HBD_P_SLEEP_N]), .bridge_out_a_hs(ahs),
        .bridge_out_a_ls(als), .bridge_out_b_hs(bhs), .bridge_out_b_ls(bls),
        .protection_trip_n(trip_n), .charge_pump_en(pump), .aux_regulator_out(aux),
        .clocks_run(clk_run), .drive_ready(ready));

    hbd_host_model u_hbd_host_model (.sys_clk(sys_clk), .drive_ready(ready), .pins(p));

    // Clock and hang limit
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Settle n edges, then sample at the falling edge
    task automatic st(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : st

    // Bounded wait for a gate pattern
    task automatic wt(input logic [3:0] g);
        for (int k = 0; k < 900 && gt !== g; k++) st(0);
    endtask : wt

    task automatic go(input int i, input logic v, input int n, input logic [3:0] g);
        u_hbd_host_model.put(i, v);
        st(n);
        chk("gates", g, gt);
    endtask : go

    // Classic single Wishbone cycle, held until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic t_chop();
        u_hbd_host_model.put(`HBD_P_SENSE, 1'b1);
        u_hbd_host_model.put(`HBD_P_PHASE, 1'b1);
        go(`HBD_P_ENABLE, 1'b1, 5, 4'b1001);
        st(58);
        chk("gates", 4'b1001, gt);
        st(25);
        chk("gates", 4'b0101, gt);
        st(150);
        chk("gates", 4'b0101, gt);
        wb(1'b0, `HBD_ADR_CHOPS, 32'h0);
        chk("chops", 32'h1, q);
    endtask : t_chop

    task automatic t_fast();
        u_hbd_host_model.put(`HBD_P_DECAY, 1'b1);
        wt(4'b0110);
        chk("gates", 4'b0110, gt);
        go(`HBD_P_ZERO, 1'b1, 5, 4'b0000);
        u_hbd_host_model.put(`HBD_P_ZERO, 1'b0);
        u_hbd_host_model.put(`HBD_P_DECAY_OPEN, 1'b1);
        st(5);
        wb(1'b0, `HBD_ADR_STATUS, 32'h0);
        chk("decay", 32'h2, q[9:8]);
        u_hbd_host_model.put(`HBD_P_DECAY_OPEN, 1'b0);
    endtask : t_fast

    task automatic t_disable();
        wt(4'b1001);
        go(`HBD_P_ENABLE, 1'b0, 5, 4'b0110);
        go(`HBD_P_ZERO, 1'b1, 5, 4'b0000);
        u_hbd_host_model.put(`HBD_P_ZERO, 1'b0);
        u_hbd_host_model.put(`HBD_P_PHASE, 1'b0);
        go(`HBD_P_ENABLE, 1'b1, 5, 4'b0110);
        u_hbd_host_model.put(`HBD_P_DECAY, 1'b0);
        go(`HBD_P_ENABLE, 1'b0, 5, 4'b0101);
        go(`HBD_P_ZERO, 1'b1, 5, 4'b0101);
        u_hbd_host_model.put(`HBD_P_ZERO, 1'b0);
    endtask : t_disable

    task automatic t_faults();
        u_hbd_host_model.put(`HBD_P_ENABLE, 1'b1);
        go(`HBD_P_HOT, 1'b1, 5, 4'b0000);
        chk("trip", 1'b0, trip_n);
        u_hbd_host_model.put(`HBD_P_HOT, 1'b0);
        st(5);
        chk("trip", 1'b1, trip_n);
        go(12, 1'b1, 70, 4'b0000);
        chk("trip", 1'b0, trip_n);
        u_hbd_host_model.put(12, 1'b0);
        wb(1'b0, `HBD_ADR_STATUS, 32'h0);
        chk("latch", {1'b0, 1'b1}, {trip_n, q[4]});
        go(`HBD_P_CLEAR_N, 1'b0, 5, 4'b0000);
        chk("trip", 1'b1, trip_n);
        u_hbd_host_model.put(`HBD_P_CLEAR_N, 1'b1);
    endtask : t_faults

    task automatic t_power();
        go(`HBD_P_LOW_SUPPLY, 1'b1, 5, 4'b0000);
        chk("power", 4'h0, {pump, aux, clk_run, ready});
        u_hbd_host_model.put(`HBD_P_LOW_SUPPLY, 1'b0);
        u_hbd_host_model.wake(ok);
        chk("ready", 1'b1, ok);
        go(`HBD_P_SLEEP_N, 1'b0, 5, 4'b0000);
        chk("power", 4'h0, {pump, aux, clk_run, ready});
        u_hbd_host_model.wake(ok);
        chk("ready", 1'b1, ok);
        chk("power", 4'hF, {pump, aux, clk_run, ready});
        wb(1'b1, `HBD_ADR_CTRL, 32'h1);
        wb(1'b0, `HBD_ADR_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        wb(1'b1, `HBD_ADR_CTRL, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask : t_power

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        u_hbd_host_model.wake(ok);
        chk("ready", 1'b1, ok);
        t_chop();
        t_fast();
        t_disable();
        t_faults();
        t_power();
        complete_run();
    end
endmodule : test_hbd_bridge_ctrl
`default_nettype wire
